// File: rtl/qah_host.sv
// Host controller that starts a four-channel conversion and reads back the results
`timescale 1ns/1ps
`default_nettype none
module qah_host
    import qah_pkg::*;
#(
    parameter int CONV_WAIT = CONV_DELAY_CYC,
    parameter int EXTRA_WAIT = WAIT_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic startReq,
    input wire logic useDelay,
    input wire logic convDoneN,
    input wire logic [DATA_W-1:0] adcData,
    output logic convStartN,
    output logic chipSelN,
    output logic readN,
    output logic dataAckN,
    output logic busy,
    output logic wordValid,
    input wire logic wordReady,
    output logic [CHAN_W-1:0] wordChan,
    output logic [DATA_W-1:0] wordData
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] doneSync_r;
    logic doneLow;          // Agreed completion level
    logic doneLow_r;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            doneSync_r <= 3'h7;
            doneLow_r <= 1'b0;
        end else begin
            doneSync_r <= {doneSync_r[1:0], convDoneN};
            doneLow_r <= doneLow;
        end
    end
    assign doneLow = (doneSync_r[2:1] == 2'h0) ? 1'b1 :
                     (doneSync_r[2:1] == 2'h3) ? 1'b0 : doneLow_r;

    // Data bus crosses in through the same three stages. The read strobe stands
    // far longer than the three edges the stages need to agree; a strobe shorter
    // than that would hand over a stale word.
    logic [DATA_W-1:0] adcSync_r [3];
    logic [DATA_W-1:0] adcLevel;    // Agreed data bus value
    logic [DATA_W-1:0] adcLevel_r;

    // Shift the bus in and hold the last agreed value
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < 3; i++) begin
                adcSync_r[i] <= '0;
            end
            adcLevel_r <= '0;
        end else begin
            adcSync_r[0] <= adcData;
            adcSync_r[1] <= adcSync_r[0];
            adcSync_r[2] <= adcSync_r[1];
            adcLevel_r <= adcLevel;
        end
    end
    assign adcLevel = (adcSync_r[2] == adcSync_r[1]) ? adcSync_r[2] : adcLevel_r;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_CONV, ST_RDLOW, ST_RDWAIT, ST_PUSH, ST_GAP
    } qah_state_e;

    qah_state_e state_r;
    qah_state_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CHAN_W-1:0] chan_r;
    logic [CHAN_W-1:0] chan_nxt;
    logic [DATA_W-1:0] sample_r;
    logic [DATA_W-1:0] sample_nxt;
    qah_pins_s pins_r;
    qah_pins_s pins_nxt;
    logic busy_r;
    logic busy_nxt;
    logic pushValid;
    logic pushReady;
    qah_word_s pushWord;
    qah_word_s outWord;
    logic outValid;

    // Width-cast helper for loading the down-counter
    function automatic logic [CNT_W-1:0] cycles(input int n);
        cycles = CNT_W'(n);
    endfunction : cycles

    assign pushValid = (state_r == ST_PUSH);
    assign pushWord = '{chan: chan_r, data: sample_r};

    // Next state: start pulse, wait for completion, four paced reads
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        chan_nxt = chan_r;
        sample_nxt = sample_r;
        pins_nxt = pins_r;
        busy_nxt = busy_r;
        unique case (state_r)
            ST_IDLE: begin
                if (startReq) begin
                    pins_nxt.convStartN = 1'b0;
                    cnt_nxt = cycles(START_LOW_CYC);
                    busy_nxt = 1'b1;
                    state_nxt = ST_START;
                end
            end
            ST_START: begin
                if (cnt_r <= 1) begin
                    pins_nxt.convStartN = 1'b1;
                    chan_nxt = '0;
                    cnt_nxt = cycles(CONV_WAIT);
                    state_nxt = ST_CONV;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_CONV: begin
                // No read is issued until completion or the delay ends
                if ((!useDelay && doneLow) || (useDelay && cnt_r <= 1)) begin
                    pins_nxt.chipSelN = 1'b0;
                    pins_nxt.readN = 1'b0;
                    cnt_nxt = cycles(READ_LOW_CYC);
                    state_nxt = ST_RDLOW;
                end else if (cnt_r != 0) begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_RDLOW: begin
                if (cnt_r <= 1) begin
                    cnt_nxt = cycles(EXTRA_WAIT);
                    state_nxt = ST_RDWAIT;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_RDWAIT: begin
                if (cnt_r <= 1) begin
                    sample_nxt = adcLevel;
                    pins_nxt.readN = 1'b1;
                    pins_nxt.chipSelN = 1'b1;
                    state_nxt = ST_PUSH;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_PUSH: begin
                // Stall here while the buffer is full so no word is lost
                if (pushReady) begin
                    chan_nxt = chan_r + 1'b1;
                    cnt_nxt = cycles(READ_GAP_CYC);
                    state_nxt = ST_GAP;
                end
            end
            ST_GAP: begin
                if (cnt_r > 1) begin
                    cnt_nxt = cnt_r - 1'b1;
                end else if (chan_r == '0) begin
                    busy_nxt = 1'b0;                    // Four reads done
                    state_nxt = ST_IDLE;
                end else begin
                    pins_nxt.chipSelN = 1'b0;
                    pins_nxt.readN = 1'b0;
                    cnt_nxt = cycles(READ_LOW_CYC);
                    state_nxt = ST_RDLOW;
                end
            end
            default: begin
                state_nxt = ST_IDLE;                    // Unused code falls back to idle
            end
        endcase
    end

    // Register sequencer state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            chan_r <= '0;
            sample_r <= '0;
            pins_r <= '{convStartN: 1'b1, chipSelN: 1'b1, readN: 1'b1};
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            chan_r <= chan_nxt;
            sample_r <= sample_nxt;
            pins_r <= pins_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ------------------------------------------------------------
    // Output buffer and pins
    // ------------------------------------------------------------
    qah_buf2 u_buf (
        .sys_clk(sys_clk),
        .srst(srst),
        .inValid(pushValid),
        .inReady(pushReady),
        .inWord(pushWord),
        .outValid(outValid),
        .outReady(wordReady),
        .outWord(outWord)
    );

    assign convStartN = pins_r.convStartN;
    assign chipSelN = pins_r.chipSelN;
    assign readN = pins_r.readN;
    assign dataAckN = pins_r.chipSelN;
    assign busy = busy_r;
    assign wordValid = outValid;
    assign wordChan = outWord.chan;
    assign wordData = outWord.data;
endmodule : qah_host
`default_nettype wire

// File: rtl/qah_pkg.sv
// Package for the quad converter host read glue: timing constants, widths and the word and pin types
package qah_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int START_LOW_NS = 100;      // Start pulse width, plain default
    localparam int START_LOW_CYC = (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_LOW_NS = 100;       // Base read strobe width
    localparam int READ_LOW_CYC = (READ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_CYC = 1;            // One extra wait state per read
    localparam int READ_GAP_NS = 100;       // Recovery between reads
    localparam int READ_GAP_CYC = (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_DELAY_US = 40;      // Software delay alternative to interrupt
    localparam int CONV_DELAY_CYC = CONV_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int DATA_W = 12;
    localparam int CHAN_N = 4;
    localparam int CHAN_W = 2;
    localparam int CNT_W = 16;

    // Tagged result word leaving the host
    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic [DATA_W-1:0] data;
    } qah_word_s;

    // Pins toward the converter
    typedef struct packed {
        logic convStartN;
        logic chipSelN;
        logic readN;
    } qah_pins_s;
endpackage : qah_pkg

// File: rtl/qah_buf2.sv
// Two-entry valid/ready buffer for tagged result words
`timescale 1ns/1ps
`default_nettype none
module qah_buf2
    import qah_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire qah_word_s inWord,
    output logic outValid,
    input wire logic outReady,
    output qah_word_s outWord
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    qah_word_s mem_r [DEPTH];
    qah_word_s mem_nxt [DEPTH];
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic rdIdx_r;
    logic rdIdx_nxt;
    logic wrIdx_r;
    logic wrIdx_nxt;
    logic push;
    logic pop;

    assign inReady = (cnt_r != 2'h2);   // Honest full stalls the reader
    assign outValid = (cnt_r != 2'h0);
    assign outWord = mem_r[rdIdx_r];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Next state of pointers and storage
    always_comb begin
        mem_nxt = mem_r;
        cnt_nxt = cnt_r;
        rdIdx_nxt = rdIdx_r;
        wrIdx_nxt = wrIdx_r;
        if (push) begin
            mem_nxt[wrIdx_r] = inWord;
            wrIdx_nxt = ~wrIdx_r;
        end
        if (pop) begin
            rdIdx_nxt = ~rdIdx_r;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 2'h1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    // Register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_r <= 2'h0;
            rdIdx_r <= 1'b0;
            wrIdx_r <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            cnt_r <= cnt_nxt;
            rdIdx_r <= rdIdx_nxt;
            wrIdx_r <= wrIdx_nxt;
            mem_r <= mem_nxt;
        end
    end
endmodule : qah_buf2
`default_nettype wire

// File: dv/qah_host_assertions.sv
// Checker for the host glue port timing, bound to qah_host
`timescale 1ns/1ps
`default_nettype none
module qah_host_assertions
    import qah_pkg::*;
#(
    parameter int CONV_WAIT = CONV_DELAY_CYC,
    parameter int EXTRA_WAIT = WAIT_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic startReq,
    input wire logic convStartN,
    input wire logic chipSelN,
    input wire logic readN,
    input wire logic dataAckN,
    input wire logic busy,
    input wire logic wordValid,
    input wire logic wordReady,
    input wire logic [CHAN_W-1:0] wordChan,
    input wire logic [DATA_W-1:0] wordData
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_startWidth;
        $fell(convStartN) |-> ##9 !convStartN ##1 convStartN;
    endproperty
    a_startWidth: assert property (p_startWidth) else $error("start pulse width wrong");
    property p_startTaken;
        !busy && startReq && convStartN |=> !convStartN ##1 busy;
    endproperty
    a_startTaken: assert property (p_startTaken) else $error("idle start not taken");
    property p_startIdle;
        $fell(convStartN) |-> $past(startReq) && !$past(busy);
    endproperty
    a_startIdle: assert property (p_startIdle) else $error("start while busy");
    property p_noReadInConv;
        !convStartN |-> readN && chipSelN;
    endproperty
    a_noReadInConv: assert property (p_noReadInConv) else $error("read during start");
    property p_readFromCs;
        readN == chipSelN;
    endproperty
    a_readFromCs: assert property (p_readFromCs) else $error("read strobe apart from select");
    property p_ackIsCs;
        dataAckN == chipSelN;
    endproperty
    a_ackIsCs: assert property (p_ackIsCs) else $error("ack differs from select");
    property p_readWidth;
        $fell(readN) |-> !readN[*8] ##1 !readN[*3] ##1 readN;
    endproperty
    a_readWidth: assert property (p_readWidth) else $error("read strobe not 11 cycles");
    property p_readGap;
        $rose(readN) |-> readN[*8] ##1 readN[*2];
    endproperty
    a_readGap: assert property (p_readGap) else $error("read recovery too short");
    property p_wordHold;
        wordValid && !wordReady |=> wordValid && $stable(wordChan) && $stable(wordData);
    endproperty
    a_wordHold: assert property (p_wordHold) else $error("stalled word changed");
endmodule : qah_host_assertions

bind qah_host qah_host_assertions #(.CONV_WAIT(CONV_WAIT), .EXTRA_WAIT(EXTRA_WAIT)) u_chk (
    .sys_clk(sys_clk), .srst(srst), .startReq(startReq), .convStartN(convStartN),
    .chipSelN(chipSelN), .readN(readN), .dataAckN(dataAckN), .busy(busy),
    .wordValid(wordValid), .wordReady(wordReady), .wordChan(wordChan), .wordData(wordData));
`default_nettype wire

// File: dv/qah_adc_model.sv
// Behavioural four-channel converter on the far side of the host glue
`timescale 1ns/1ps
`default_nettype none
module qah_adc_model
    import qah_pkg::*;
(
    input wire logic convStartN,
    input wire logic chipSelN,
    input wire logic readN,
    input wire logic slowConv,
    input wire logic [4*DATA_W-1:0] samples,
    output logic convDoneN,
    output logic [DATA_W-1:0] adcData,
    output logic readInConv
);
    logic armed = 1'h0;
    logic busyConv = 1'h0;
    logic firstRd = 1'h0;
    logic [1:0] ptr = 2'h0;
    logic [DATA_W-1:0] lastData = '0;
    initial convDoneN = 1'h1;
    initial readInConv = 1'h0;
    // Only a real low pulse arms a conversion, not the power-up edge
    always @(negedge convStartN) begin
        armed = 1'h1;
        busyConv = 1'h1;
    end
    // Rising start rewinds the pointer; completion after all four channels
    always @(posedge convStartN) if (armed) begin
        ptr = 2'h0;
        #(slowConv ? 1500 : 200);
        busyConv = 1'h0;
        convDoneN = 1'h0;
        firstRd = 1'h1;
    end
    // First falling read edge releases completion; early reads are flagged
    always @(negedge readN) begin
        if (busyConv) readInConv = 1'h1;
        if (firstRd) convDoneN = 1'h1;
        firstRd = 1'h0;
    end
    // Pointer steps itself after each read
    always @(posedge readN) begin
        lastData = samples[ptr*DATA_W +: DATA_W];
        ptr = ptr + 2'h1;
    end
    // Released bus shows the inverse so a stale sample cannot pass
    assign adcData = (!readN && !chipSelN) ? samples[ptr*DATA_W +: DATA_W] : ~lastData;
endmodule : qah_adc_model
`default_nettype wire

// File: dv/qah_host_tb_top.sv
// Self-checking testbench for the quad converter host glue
`timescale 1ns/1ps
`default_nettype none
module qah_host_tb_top
    import qah_pkg::*;
;
    logic sys_clk, srst, startReq, useDelay, convDoneN, wordReady, slowConv, stallAll;
    logic convStartN, chipSelN, readN, dataAckN, busy, wordValid, readInConv;
    logic [DATA_W-1:0] adcData, wordData;
    logic [CHAN_W-1:0] wordChan;
    logic [4*DATA_W-1:0] samples;
    logic [31:0] rng, rdyRng;
    int num_errors, checks, starts;
    qah_word_s got[$];

    qah_host #(.CONV_WAIT(50), .EXTRA_WAIT(1)) DUT (.sys_clk(sys_clk), .srst(srst),
        .startReq(startReq), .useDelay(useDelay), .convDoneN(convDoneN), .adcData(adcData),
        .convStartN(convStartN), .chipSelN(chipSelN), .readN(readN), .dataAckN(dataAckN),
        .busy(busy), .wordValid(wordValid), .wordReady(wordReady), .wordChan(wordChan),
        .wordData(wordData));
    qah_adc_model u_adc (.convStartN(convStartN), .chipSelN(chipSelN), .readN(readN),
        .slowConv(slowConv), .samples(samples), .convDoneN(convDoneN), .adcData(adcData),
        .readInConv(readInConv));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [13:0] expWord(input int k);
        return {k[1:0], samples[k*DATA_W +: DATA_W]};
    endfunction : expWord
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // Clock, consumer with random stalls, collector and start counter
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        rdyRng = xs(rdyRng);
        wordReady <= !stallAll && rdyRng[0];
    end
    always @(posedge sys_clk) if (wordValid === 1'h1 && wordReady === 1'h1) got.push_back({wordChan, wordData});
    always @(negedge convStartN) starts++;

    // One sequence; startReq held high while busy must be refused
    task automatic run_seq(input logic dly, input logic slow, input logic stall);
        int n;
        int s0;
        s0 = starts;
        rng = xs(rng);
        samples[47:24] = rng[23:0];
        rng = xs(rng);
        samples[23:0] = rng[23:0];
        {useDelay, slowConv, stallAll, startReq} = {dly, slow, stall, 1'h1};
        repeat (30) @(negedge sys_clk);
        startReq = 1'h0;
        if (stall) begin
            repeat (400) @(negedge sys_clk);
            check({wordValid, 31'(got.size())}, 32'h80000000, "buffer not holding");
            stallAll = 1'h0;
        end
        n = 0;
        while (busy !== 1'h0 && n < 5000) begin
            @(negedge sys_clk);
            n++;
        end
        check(busy, 1'h0, "sequence hung");
        repeat (20) @(negedge sys_clk);
        check(starts - s0, 1, "start count");
        check(readInConv, 1'h0, "read during conversion");
        check(got.size(), 4, "word count");
        for (int k = 0; k < 4 && got.size() > 0; k++) check(got.pop_front(), expWord(k), "word");
        got.delete();
        $display("sequence done delay=%0d slow=%0d stall=%0d", dly, slow, stall);
    endtask : run_seq

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {srst, startReq, useDelay, slowConv, stallAll} = 5'h10;
        {rng, rdyRng, num_errors, checks, starts} = {32'h527a73ba, 32'h527a73ba, 96'h0};
        samples = '0;
        repeat (5) @(negedge sys_clk);
        srst = 1'h0;
        check({convStartN, chipSelN, readN, dataAckN, busy, wordValid}, 6'h3c, "reset outputs");
        run_seq(1'h0, 1'h1, 1'h0);
        run_seq(1'h1, 1'h0, 1'h0);
        run_seq(1'h0, 1'h0, 1'h1);
        for (int i = 0; i < 5; i++) run_seq(rng[4], !rng[4] && rng[5], 1'h0);
        print_verdict();
    end
    initial begin
        #400000;
        num_errors++;
        print_verdict();
    end
endmodule : qah_host_tb_top
`default_nettype wire
